// File: hw/adcb_map.svh
`ifndef ADCB_MAP_SVH
`define ADCB_MAP_SVH

// Address decode: bits 7:6 select the converter, bits 5:4 the operation.
`define ADCB_BASE_SEL        2'h2
`define ADCB_OP_ALE          2'h0
`define ADCB_OP_START        2'h1
`define ADCB_OP_BOTH         2'h2
`define ADCB_OP_STATUS       2'h0
`define ADCB_OP_RESULT       2'h1
`define ADCB_EOC_BIT         0

// Timing, in source units and derived cycle counts.
`define ADCB_SYS_CLK_MHZ     40
`define ADCB_CONV_CLK_KHZ    1000
`define ADCB_DIV_HALF_CYC    ((`ADCB_SYS_CLK_MHZ * 1000) / (2 * `ADCB_CONV_CLK_KHZ))
`define ADCB_SETTLE_NS       2000
`define ADCB_SETTLE_CYC      ((`ADCB_SETTLE_NS * `ADCB_SYS_CLK_MHZ + 999) / 1000)
`define ADCB_PULSE_NS        500
`define ADCB_PULSE_CYC       ((`ADCB_PULSE_NS * `ADCB_SYS_CLK_MHZ + 999) / 1000)
`define ADCB_EOC_LOW_PERIODS 8
`define ADCB_REARM_CYC       (`ADCB_EOC_LOW_PERIODS * 2 * `ADCB_DIV_HALF_CYC)

`endif

// File: hw/adcb_pkg.sv
package adcb_pkg;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_HOLD    = 4'b0010,
        ST_GAP     = 4'b0100,
        ST_REPULSE = 4'b1000
    } adcb_state_e;

    typedef enum logic [1:0] {
        SM_NONE    = 2'h0,
        SM_STRETCH = 2'h1,
        SM_DOUBLE  = 2'h2,
        SM_SPARE   = 2'h3
    } adcb_settle_e;

    typedef logic [7:0] adcb_byte_t;
    typedef logic [3:0] adcb_nib_t;
    typedef logic [8:0] adcb_cnt_t;

endpackage

// File: hw/adcb_pin_sync.sv
module adcb_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    // Pin side
    input  wire logic [WIDTH-1:0] pin_i,
    // Filtered value
    output logic      [WIDTH-1:0] value_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    wire              agree = (s2 == s3);

    // A value is accepted only once the last two stages agree.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1      <= '0;
            s2      <= '0;
            s3      <= '0;
            value_o <= '0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (agree) begin
                value_o <= s3;
            end
        end
    end
endmodule

// File: hw/adcb_ctrl.sv
// Functional notes
// - Pulses positive, lasting as long as strobe.
// - Decode latch, start, status and result operations.
// - Channel select from address or data bus.
// - Comparator input settles before conversion starts.
// - Combined pulse may be stretched for settling.
// - Or combined pulse repeated after settling.
// - Result enable only from decoded read.
// - Latch and start come from writes.
// - Rising end of conversion requests interrupt.
// - Status read puts end of conversion on data.
// - Optional: every result read while idle starts conversion.
// - Divide system clock down to converter clock.
// - No interrupt re-arm within eight converter clocks.
// - Interrupt flag set on rise, cleared by acknowledge.
`include "adcb_map.svh"

module adcb_ctrl (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rstn_i,
    // Processor bus
    input  wire logic [7:0]            cpu_addr_i,
    input  wire logic [7:0]            cpu_wdata_i,
    input  wire logic                  cpu_rd_i,
    input  wire logic                  cpu_wr_i,
    output adcb_pkg::adcb_byte_t       cpu_rdata_o,
    output logic                       cpu_rdata_oe_o,
    // Processor interrupt
    input  wire logic                  cpu_interrupt_acknowledge_n_i,
    output logic                       cpu_interrupt_request_n_o,
    // Configuration straps
    input  wire logic                  chan_from_addr_i,
    input  wire logic                  start_on_read_i,
    input  adcb_pkg::adcb_settle_e     settle_mode_i,
    // Converter pins
    output adcb_pkg::adcb_nib_t        conv_chan_o,
    output logic                       conv_ale_o,
    output logic                       conv_start_o,
    output logic                       conv_oe_o,
    output logic                       conv_clk_o,
    input  wire logic                  conv_eoc_i,
    input  wire logic [7:0]            conv_data_i
);
    import adcb_pkg::*;

    function automatic logic op_hit(input logic [7:0] addr, input logic [1:0] op);
        op_hit = (addr[7:6] == `ADCB_BASE_SEL) && (addr[5:4] == op);
    endfunction

    adcb_state_e state;
    adcb_state_e next_state;
    adcb_cnt_t   cnt;
    adcb_cnt_t   rearm_cnt;
    adcb_cnt_t   div_cnt;
    logic        ale_d;
    logic        start_d;
    logic        oe_d;
    logic        both_q;
    logic        eoc_sync;
    logic        eoc_q;
    adcb_byte_t  data_sync;

    wire logic       idle     = (state == ST_IDLE);
    wire logic       wr_ale   = cpu_wr_i && op_hit(cpu_addr_i, `ADCB_OP_ALE);
    wire logic       wr_start = cpu_wr_i && op_hit(cpu_addr_i, `ADCB_OP_START);
    wire logic       wr_both  = cpu_wr_i && op_hit(cpu_addr_i, `ADCB_OP_BOTH);
    wire logic       rd_stat  = cpu_rd_i && op_hit(cpu_addr_i, `ADCB_OP_STATUS);
    wire logic       rd_res   = cpu_rd_i && op_hit(cpu_addr_i, `ADCB_OP_RESULT);
    wire adcb_nib_t  next_chan = chan_from_addr_i ? cpu_addr_i[3:0] : cpu_wdata_i[3:0];
    wire logic       both_end = both_q && !wr_both;
    // The first idle cycle after a stretched combined write bridges into the
    // hold state, so the stretched pulse never shows a one-cycle dropout.
    wire logic       hold_go  = idle && both_end && (settle_mode_i == SM_STRETCH);
    wire logic       pulse_st = (state == ST_HOLD) || (state == ST_REPULSE) || hold_go;
    wire logic       ale_cond = (idle && (wr_ale || wr_both)) || pulse_st;
    wire logic       read_go  = start_on_read_i && rd_res;
    wire logic       start_cond = (idle && (wr_start || wr_both || read_go)) || pulse_st;
    wire logic       cnt_settle = (cnt == 9'(`ADCB_SETTLE_CYC - 1));
    wire logic       cnt_pulse  = (cnt == 9'(`ADCB_PULSE_CYC - 1));
    wire logic       eoc_rise = eoc_sync && !eoc_q;
    wire logic       irq_set  = eoc_rise && (rearm_cnt == 9'h000);
    wire logic       next_irq = irq_set ||
                                (!cpu_interrupt_request_n_o && cpu_interrupt_acknowledge_n_i);
    wire logic       div_wrap = (div_cnt == 9'(`ADCB_DIV_HALF_CYC - 1));
    wire adcb_byte_t next_rdata = rd_res  ? data_sync :
                                  rd_stat ? 8'(eoc_sync) << `ADCB_EOC_BIT : 8'h00;

    adcb_pin_sync #(.WIDTH(1)) u_eoc_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (conv_eoc_i),
        .value_o   (eoc_sync)
    );

    adcb_pin_sync #(.WIDTH(8)) u_data_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (conv_data_i),
        .value_o   (data_sync)
    );

    // In stretch or double mode, a combined write arms the settling sequence once its strobe ends.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (both_end && settle_mode_i == SM_STRETCH) begin
                    next_state = ST_HOLD;
                end else if (both_end && settle_mode_i == SM_DOUBLE) begin
                    next_state = ST_GAP;
                end
            end
            ST_HOLD: begin
                if (cnt_settle) begin
                    next_state = ST_IDLE;
                end
            end
            ST_GAP: begin
                if (cnt_settle) begin
                    next_state = ST_REPULSE;
                end
            end
            ST_REPULSE: begin
                if (cnt_pulse) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state  <= ST_IDLE;
            cnt    <= 9'h000;
            both_q <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= (next_state != state) ? 9'h000 : 9'(cnt + 9'h001);
            both_q <= wr_both && idle;
        end
    end

    // The channel is driven one cycle before the latch strobe rises, so the
    // converter never samples a channel that is still changing.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ale_d        <= 1'b0;
            start_d      <= 1'b0;
            oe_d         <= 1'b0;
            conv_ale_o   <= 1'b0;
            conv_start_o <= 1'b0;
            conv_oe_o    <= 1'b0;
            conv_chan_o  <= 4'h0;
        end else begin
            ale_d        <= ale_cond;
            start_d      <= start_cond;
            oe_d         <= rd_res;
            conv_ale_o   <= ale_d;
            conv_start_o <= start_d;
            conv_oe_o    <= oe_d;
            if (idle && (wr_ale || wr_both) && !ale_d) begin
                conv_chan_o <= next_chan;
            end
        end
    end

    // End of conversion stays low for up to eight converter clocks after
    // start, so a rise seen in that window is stale and is not taken.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eoc_q                     <= 1'b0;
            rearm_cnt                 <= 9'h000;
            cpu_interrupt_request_n_o <= 1'b1;
        end else begin
            eoc_q <= eoc_sync;
            if (conv_start_o && !start_d) begin
                rearm_cnt <= 9'(`ADCB_REARM_CYC);
            end else if (rearm_cnt != 9'h000) begin
                rearm_cnt <= 9'(rearm_cnt - 9'h001);
            end
            cpu_interrupt_request_n_o <= !next_irq;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_rdata_o    <= 8'h00;
            cpu_rdata_oe_o <= 1'b0;
            div_cnt        <= 9'h000;
            conv_clk_o     <= 1'b0;
        end else begin
            cpu_rdata_o    <= next_rdata;
            cpu_rdata_oe_o <= rd_res || rd_stat;
            div_cnt        <= div_wrap ? 9'h000 : 9'(div_cnt + 9'h001);
            if (div_wrap) begin
                conv_clk_o <= !conv_clk_o;
            end
        end
    end

    AST_CHAN_STABLE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        conv_ale_o && $past(conv_ale_o) |-> $stable(conv_chan_o))
        else $error("Channel changed while latch strobe high.");

    AST_OE_FROM_READ: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(conv_oe_o) |-> $past(cpu_rd_i && (cpu_addr_i[7:6] == `ADCB_BASE_SEL) &&
                                   (cpu_addr_i[5:4] == `ADCB_OP_RESULT), 2))
        else $error("Result enable without decoded result read.");

    AST_START_CAUSE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(conv_start_o) |-> $past(cpu_wr_i || (start_on_read_i && cpu_rd_i) || !idle, 2))
        else $error("Start pulse without a decoded cause.");

    AST_READ_STARTS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        start_on_read_i && rd_res && idle |-> ##2 conv_start_o)
        else $error("Result read did not start a conversion.");

    AST_STRETCH: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        state == ST_HOLD |-> ##2 (conv_ale_o && conv_start_o))
        else $error("Stretched pulse dropped early.");

    AST_GAP_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        state == ST_GAP && $past(state) == ST_GAP |-> ##2 !conv_start_o)
        else $error("Start high during settling gap.");

    AST_SETTLE_LEN: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(state == ST_REPULSE) |-> $past(cnt) == 9'(`ADCB_SETTLE_CYC - 1))
        else $error("Second pulse before settling time.");

    AST_IRQ_SET: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        irq_set |=> !cpu_interrupt_request_n_o)
        else $error("Interrupt not raised on end of conversion.");

    AST_IRQ_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !cpu_interrupt_acknowledge_n_i && !irq_set |=> cpu_interrupt_request_n_o)
        else $error("Interrupt not cleared by acknowledge.");

    AST_REARM: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rearm_cnt != 9'h000 && cpu_interrupt_request_n_o |=> cpu_interrupt_request_n_o)
        else $error("Interrupt re-armed inside the hold-off window.");

    AST_DIV: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        conv_clk_o != $past(conv_clk_o) |-> div_cnt == 9'h000)
        else $error("Converter clock toggled off its divider count.");
endmodule

// File: bench/adcb_conv_model.sv
module adcb_conv_model #(
    parameter int CONV_PER = 10
) (
    // Controls from the controller
    input  wire logic       conv_clk_i,
    input  wire logic       ale_i,
    input  wire logic       start_i,
    input  wire logic       oe_i,
    input  wire logic [3:0] chan_i,
    // Converter outputs
    output logic            eoc_o,
    output logic [7:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] chan_reg = 4'h0;
    logic [7:0] result   = 8'h00;
    int         cnt      = 0;

    initial eoc_o = 1'b0;

    always @(posedge ale_i) chan_reg <= chan_i;

    // Any falling start restarts the conversion, so a start tied to result
    // reads runs back to back.
    always @(negedge start_i) begin
        eoc_o <= 1'b0;
        cnt   <= CONV_PER;
    end

    always @(posedge conv_clk_i) begin
        if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                result <= {chan_reg, ~chan_reg};
                eoc_o  <= 1'b1;
            end
        end
    end

    // Released data lines show the inverse of the last result, so a stale copy never matches.
    assign data_o = oe_i ? result : ~result;
endmodule

// File: bench/test_adcb_ctrl.sv
module test_adcb_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import adcb_pkg::*;

    logic         sys_clk_i = 1'b0, rstn_i = 1'b0, cpu_rd_i = 1'b0, cpu_wr_i = 1'b0;
    logic [7:0]   cpu_addr_i = 8'h00, cpu_wdata_i = 8'h00, conv_data_i;
    logic         cpu_interrupt_acknowledge_n_i = 1'b1, chan_from_addr_i = 1'b0;
    logic         start_on_read_i = 1'b0, conv_eoc_i, was_oe = 1'b0;
    adcb_settle_e settle_mode_i = SM_NONE;
    adcb_byte_t   cpu_rdata_o, last_rd = 8'h00;
    adcb_nib_t    conv_chan_o;
    logic         cpu_rdata_oe_o, cpu_interrupt_request_n_o, conv_ale_o, conv_start_o;
    logic         conv_oe_o, conv_clk_o;
    int           err_count = 0, num_checks = 0, ale_w = 0, st_w = 0;
    logic [31:0]  q_ale[$], q_rd[$], q_st[$];

    adcb_ctrl i_adcb_ctrl (.sys_clk_i, .rstn_i, .cpu_addr_i, .cpu_wdata_i, .cpu_rd_i, .cpu_wr_i,
        .cpu_rdata_o, .cpu_rdata_oe_o, .cpu_interrupt_acknowledge_n_i, .cpu_interrupt_request_n_o,
        .chan_from_addr_i, .start_on_read_i, .settle_mode_i, .conv_chan_o, .conv_ale_o,
        .conv_start_o, .conv_oe_o, .conv_clk_o, .conv_eoc_i, .conv_data_i);

    adcb_conv_model i_adcb_conv_model (.conv_clk_i(conv_clk_o), .ale_i(conv_ale_o),
        .start_i(conv_start_o), .oe_i(conv_oe_o), .chan_i(conv_chan_o), .eoc_o(conv_eoc_i),
        .data_o(conv_data_i));

    initial forever #12.5 sys_clk_i = ~sys_clk_i;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                       input int len);
        cpu_addr_i  = addr;
        cpu_wdata_i = data;
        if (wr) cpu_wr_i = 1'b1;
        else cpu_rd_i = 1'b1;
        cyc(len);
        cpu_wr_i = 1'b0;
        cpu_rd_i = 1'b0;
        cyc(1);
    endtask

    task automatic irq_ack();
        for (int i = 0; i < 1000 && cpu_interrupt_request_n_o !== 1'b0; i++) cyc(1);
        check(cpu_interrupt_request_n_o, 1'b0);
        cpu_interrupt_acknowledge_n_i = 1'b0;
        cyc(2);
        cpu_interrupt_acknowledge_n_i = 1'b1;
        cyc(2);
        check(cpu_interrupt_request_n_o, 1'b1);
    endtask

    task automatic read_result(input adcb_nib_t ch);
        q_rd.push_back({ch, ~ch});
        bus(1'b0, 8'h90, 8'h00, 10);
    endtask

    // A pulse or read with no note waiting is itself a mismatch, so stray strobes are caught.
    // Outputs are sampled mid-cycle, well away from the edge that launches them.
    always @(negedge sys_clk_i) begin
        if (conv_ale_o === 1'b1) ale_w++;
        else if (ale_w > 0) begin
            check(ale_w, q_ale.size() > 0 ? q_ale.pop_front() : 32'hdead);
            ale_w = 0;
        end
        if (conv_start_o === 1'b1) st_w++;
        else if (st_w > 0) begin
            check(st_w, q_st.size() > 0 ? q_st.pop_front() : 32'hdead);
            st_w = 0;
        end
        if (cpu_rdata_oe_o === 1'b1) last_rd = cpu_rdata_o;
        else if (was_oe === 1'b1) begin
            check(last_rd, q_rd.size() > 0 ? q_rd.pop_front() : 32'hdead);
        end
        was_oe = cpu_rdata_oe_o;
    end

    // About eight times the expected run length.
    initial begin
        #500000;
        err_count++;
        complete_run();
    end

    initial begin
        logic [7:0] rnd;
        time        t0;
        rnd = 8'h3a;
        cyc(5);
        rstn_i = 1'b1;
        check({conv_ale_o, conv_start_o, conv_oe_o, cpu_interrupt_request_n_o}, 4'h1);
        @(posedge conv_clk_o);
        t0 = $time;
        @(posedge conv_clk_o);
        check(32'(($time - t0) / 25), 40);
        cyc(1);
        rnd = lfsr(rnd);
        q_ale.push_back(6);
        bus(1'b1, 8'h80, rnd, 6);
        check(conv_chan_o, rnd[3:0]);
        q_st.push_back(4);
        bus(1'b1, 8'h90, 8'h00, 4);
        irq_ack();
        read_result(rnd[3:0]);
        q_rd.push_back(8'h01);
        bus(1'b0, 8'h80, 8'h00, 10);
        bus(1'b0, 8'h50, 8'h00, 10);
        chan_from_addr_i = 1'b1;
        // Stretched: 6 strobe cycles, one bridge cycle, then 80 settling cycles.
        for (int m = 0; m < 4; m++) begin
            rnd = lfsr(rnd);
            settle_mode_i = adcb_settle_e'(m);
            q_ale.push_back(m == 1 ? 87 : 6);
            q_st.push_back(m == 1 ? 87 : 6);
            if (m == 2) q_ale.push_back(20);
            if (m == 2) q_st.push_back(20);
            bus(1'b1, {4'ha, rnd[3:0]}, ~rnd, 6);
            cyc(130);
            check(conv_chan_o, rnd[3:0]);
            irq_ack();
            read_result(rnd[3:0]);
        end
        start_on_read_i = 1'b1;
        settle_mode_i = SM_NONE;
        q_st.push_back(10);
        read_result(rnd[3:0]);
        cyc(10);
        q_rd.push_back(8'h00);
        bus(1'b0, 8'h80, 8'h00, 10);
        cyc(4);
        check(q_ale.size() + q_rd.size() + q_st.size(), 0);
        complete_run();
    end
endmodule
